// [rtl/tso_pkg.sv]
// tso_pkg: register map, field positions, states and frame record
// for the transmit segmentation engine.
// assumes a single 32-bit ahb-lite register port and one clock domain.
package tso_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TSO_OFF_CTRL   = 8'h00; // start strobe
  localparam logic [7:0] TSO_OFF_ACT    = 8'h04; // offload_activation_field
  localparam logic [7:0] TSO_OFF_PAYLD  = 8'h08; // total / max payload
  localparam logic [7:0] TSO_OFF_SEQ    = 8'h0C; // prototype sequence number
  localparam logic [7:0] TSO_OFF_IPID   = 8'h10; // ip id, urgent pointer
  localparam logic [7:0] TSO_OFF_LEN    = 8'h14; // ip total length, snap length
  localparam logic [7:0] TSO_OFF_HDR    = 8'h18; // pseudo sum, flags, header size
  localparam logic [7:0] TSO_OFF_SCHED  = 8'h1C; // scheduled transmit time
  localparam logic [7:0] TSO_OFF_STAT   = 8'h20; // session status, read only
  localparam logic [7:0] TSO_OFF_TIME   = 8'h24; // free running time, read only

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TSO_CTRL_START  = 0;
  localparam int TSO_ACT_SEG     = 0;
  localparam int TSO_ACT_IPCS    = 1;
  localparam int TSO_ACT_TCPCS   = 2;
  localparam int TSO_ACT_SNAP    = 3;
  localparam int TSO_ACT_SCHED   = 4;
  localparam int TSO_STAT_BUSY   = 0;
  localparam int TSO_STAT_DONE   = 1;
  localparam int TSO_STAT_HDRERR = 2;
  localparam int TSO_STAT_FAILS  = 8;  // 8-bit failed segment count
  localparam int TSO_STAT_FRAMES = 16; // 16-bit frames sent
  // tcp flag bits inside the 6-bit flag field
  localparam int TSO_FLG_FIN     = 0;
  localparam int TSO_FLG_PSH     = 3;

  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [31:0] TSO_RST_WORD  = 32'h0000_0000;
  localparam int          TSO_HDR_BYTES = 80;
  localparam logic [31:0] TSO_DESC_PAIR = 32'h0000_0010; // two 8-byte descriptors

  // ----------------------------------------------------------------
  // engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TSO_IDLE  = 3'b000,
    TSO_SCHED = 3'b001,
    TSO_EMIT  = 3'b010,
    TSO_TXW   = 3'b011,
    TSO_STAT  = 3'b100
  } tso_state_e;

  // one rewritten segment header handed to the checksum stage
  typedef struct packed {
    logic [31:0] seq;
    logic [15:0] ip_id;
    logic [15:0] ip_tot_len;
    logic [15:0] snap_len;
    logic [15:0] pseudo_sum;
    logic [15:0] urg_ptr;
    logic [15:0] payload_len;
    logic [5:0]  flags;
    logic        snap_en;
    logic        ip_csum_req;
    logic        tcp_csum_req;
    logic        last;
  } tso_frame_s;

endpackage

// [rtl/tso_engine.sv]
// tso_engine: segments one large tcp send into frame headers.
// assumes the checksum / transmit stage on the same clock consumes
// frame records and reports each frame's outcome with tx_done.
//
// Contract
// - segmentation only when activation seg bit is 1; else one plain frame (code still cuts its lengths and pseudo sum by max minus total)
// - every frame but the last carries exactly max_segment_payload bytes
// - first frame clears fin and psh when prototype has them set
// - prototype header is at most 80 bytes; larger is refused
// - remaining = total minus frames times max; decides last frame
// - layer-2 header of intermediate frames equals first frame
// - ip identification increments by one each frame after the first
// - ip checksum requested per frame when ip checksum bit set
// - sequence = previous sequence plus previous payload, modulo 2^32
// - intermediate frames keep first-frame flags and urgent pointer
// - intermediate frames keep pseudo-header partial sum unchanged
// - tcp checksum requested per frame when tcp checksum bit set
// - ip and tcp options pass unmodified in every frame
// - last frame payload is the remaining count, at most max
// - last snap length = first snap length minus (max minus last payload)
// - last ip total length = first minus (max minus last payload)
// - last frame carries ack, urg, rst, syn from prototype
// - last frame restores fin and psh when prototype had them
// - last frame pseudo-header sum corrected for reduced length
// - one status write only after the whole session is sent
// - a failed segment does not abort; session continues
// - descriptors fetched in pairs; one extra read may occur
// - scheduled time holds all segments, then back to back
// - each rewritten segment goes through checksum then normal send
`timescale 1ns/1ps
module tso_engine
  import tso_pkg::*;
#(
  parameter int MAX_HDR = TSO_HDR_BYTES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output tso_frame_s       frm_data,
  output logic             frm_valid,
  input  wire logic        frm_ready,
  input  wire logic        tx_done,
  input  wire logic        tx_fail,
  output logic             desc_req,
  output logic [31:0]      desc_addr,
  input  wire logic [31:0] desc_base,
  output logic             stat_wr,
  output logic [7:0]       stat_fails
);

  // refuse a header limit beyond the prototype store
  if (MAX_HDR < 1 || MAX_HDR > TSO_HDR_BYTES) begin : g_bad_max_hdr
    $error("MAX_HDR outside the prototype store size");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // ones-complement subtract of b from a, end-around borrow
  function automatic logic [15:0] oc_sub(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, ~b};
    return s[15:0] + {15'h0, s[16]};
  endfunction

  // word offset match in the register window
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  logic [7:0]  dp_addr_r;
  logic        dp_wr_r;
  logic [31:0] act_r, payld_r, seq_cfg_r, ipid_r, len_r, hdr_r, sched_r;
  logic [31:0] time_r;
  logic [31:0] stat_word;
  logic        start_req;
  logic        busy_r, done_r, hdrerr_r;
  logic [15:0] frames_r;
  logic [7:0]  fails_r;
  tso_state_e  st_r;

  wire logic addr_ok = hsel & htrans[1] & hready;

  // address phase capture, one cycle data phase, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_addr_r <= 8'h00;
      dp_wr_r   <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_wr_r   <= addr_ok & hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ok)
        dp_addr_r <= {haddr[7:2], 2'b00};
    end
  end

  assign stat_word = {frames_r, fails_r, 5'h00, hdrerr_r, done_r, busy_r};

  // read data registered in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= TSO_RST_WORD;
    end else if (addr_ok && !hwrite) begin
      unique case ({haddr[7:2], 2'b00})
        TSO_OFF_ACT:   hrdata <= act_r;
        TSO_OFF_PAYLD: hrdata <= payld_r;
        TSO_OFF_SEQ:   hrdata <= seq_cfg_r;
        TSO_OFF_IPID:  hrdata <= ipid_r;
        TSO_OFF_LEN:   hrdata <= len_r;
        TSO_OFF_HDR:   hrdata <= hdr_r;
        TSO_OFF_SCHED: hrdata <= sched_r;
        TSO_OFF_STAT:  hrdata <= stat_word;
        TSO_OFF_TIME:  hrdata <= time_r;
        default:       hrdata <= TSO_RST_WORD; // unmapped and ctrl read zero
      endcase
    end
  end

  // configuration registers, locked while a session runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_r     <= TSO_RST_WORD;
      payld_r   <= TSO_RST_WORD;
      seq_cfg_r <= TSO_RST_WORD;
      ipid_r    <= TSO_RST_WORD;
      len_r     <= TSO_RST_WORD;
      hdr_r     <= TSO_RST_WORD;
      sched_r   <= TSO_RST_WORD;
    end else if (dp_wr_r && !busy_r) begin
      if (hit(dp_addr_r, TSO_OFF_ACT))   act_r     <= hwdata;
      if (hit(dp_addr_r, TSO_OFF_PAYLD)) payld_r   <= hwdata;
      if (hit(dp_addr_r, TSO_OFF_SEQ))   seq_cfg_r <= hwdata;
      if (hit(dp_addr_r, TSO_OFF_IPID))  ipid_r    <= hwdata;
      if (hit(dp_addr_r, TSO_OFF_LEN))   len_r     <= hwdata;
      if (hit(dp_addr_r, TSO_OFF_HDR))   hdr_r     <= hwdata;
      if (hit(dp_addr_r, TSO_OFF_SCHED)) sched_r   <= hwdata;
    end
  end

  assign start_req = dp_wr_r & hit(dp_addr_r, TSO_OFF_CTRL) & hwdata[TSO_CTRL_START];

  // free running time base for scheduled sends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) time_r <= TSO_RST_WORD;
    else          time_r <= time_r + 32'h0000_0001;
  end

  // ----------------------------------------------------------------
  // prototype fields
  // ----------------------------------------------------------------
  wire logic        seg_en   = act_r[TSO_ACT_SEG];
  wire logic [15:0] tot_pay  = payld_r[31:16];
  wire logic [15:0] max_pay  = {2'b00, payld_r[13:0]};
  wire logic [5:0]  pflags   = hdr_r[21:16];
  wire logic [7:0]  hdr_len  = hdr_r[31:24];
  wire logic [5:0]  finpsh   = 6'(1 << TSO_FLG_FIN) | 6'(1 << TSO_FLG_PSH); // fin, psh

  // ----------------------------------------------------------------
  // session state
  // ----------------------------------------------------------------
  logic [31:0] seq_r;
  logic [15:0] id_r, rem_r;
  logic [31:0] prod;
  logic        is_last;
  logic [15:0] pay_len, short_by;

  assign prod     = frames_r * max_pay;
  assign is_last  = !seg_en || (rem_r <= max_pay);
  assign pay_len  = (seg_en && !is_last) ? max_pay : rem_r;
  assign short_by = max_pay - pay_len;

  // control state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r     <= TSO_IDLE;
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      hdrerr_r <= 1'b0;
    end else begin
      unique case (st_r)
        TSO_IDLE: if (start_req) begin
          done_r <= 1'b0;
          if (hdr_len > 8'(MAX_HDR)) begin
            hdrerr_r <= 1'b1;
          end else begin
            hdrerr_r <= 1'b0;
            busy_r   <= 1'b1;
            st_r     <= act_r[TSO_ACT_SCHED] ? TSO_SCHED : TSO_EMIT;
          end
        end
        TSO_SCHED: if (time_r >= sched_r) st_r <= TSO_EMIT;
        TSO_EMIT:  if (frm_valid && frm_ready) st_r <= TSO_TXW;
        TSO_TXW:   if (tx_done) st_r <= is_last ? TSO_STAT : TSO_EMIT;
        TSO_STAT: begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          st_r   <= TSO_IDLE;
        end
        default:   st_r <= TSO_IDLE;
      endcase
    end
  end

  // per-frame counters: sequence, id, frames, remaining
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_r    <= TSO_RST_WORD;
      id_r     <= 16'h0000;
      frames_r <= 16'h0000;
      rem_r    <= 16'h0000;
      fails_r  <= 8'h00;
    end else if (st_r == TSO_IDLE && start_req) begin
      seq_r    <= seq_cfg_r;
      id_r     <= ipid_r[15:0];
      frames_r <= 16'h0000;
      rem_r    <= tot_pay;
      fails_r  <= 8'h00;
    end else if (st_r == TSO_TXW && tx_done) begin
      seq_r    <= seq_r + {16'h0000, pay_len};
      id_r     <= id_r + 16'h0001;
      frames_r <= frames_r + 16'h0001;
      rem_r    <= tot_pay - 16'(prod + {16'h0000, max_pay});
      if (tx_fail) fails_r <= fails_r + 8'h01;
    end
  end

  // frame record build; options and l2 bytes are never touched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frm_valid <= 1'b0;
      frm_data  <= '0;
    end else begin
      frm_valid <= 1'b0;
      if (st_r == TSO_EMIT) begin
        frm_valid             <= !(frm_valid && frm_ready);
        frm_data.seq          <= seq_r;
        frm_data.ip_id        <= id_r;
        frm_data.urg_ptr      <= ipid_r[31:16];
        frm_data.payload_len  <= pay_len;
        frm_data.snap_en      <= act_r[TSO_ACT_SNAP];
        frm_data.ip_csum_req  <= act_r[TSO_ACT_IPCS];
        frm_data.tcp_csum_req <= act_r[TSO_ACT_TCPCS];
        frm_data.last         <= is_last;
        if (is_last) begin
          frm_data.flags      <= pflags;
          frm_data.ip_tot_len <= len_r[15:0] - short_by;
          frm_data.snap_len   <= len_r[31:16] - short_by;
          frm_data.pseudo_sum <= oc_sub(hdr_r[15:0], short_by);
        end else begin
          frm_data.flags      <= pflags & ~finpsh;
          frm_data.ip_tot_len <= len_r[15:0];
          frm_data.snap_len   <= len_r[31:16];
          frm_data.pseudo_sum <= hdr_r[15:0];
        end
      end
    end
  end

  // descriptor pair fetch and completion status write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      desc_req   <= 1'b0;
      desc_addr  <= TSO_RST_WORD;
      stat_wr    <= 1'b0;
      stat_fails <= 8'h00;
    end else begin
      desc_req <= 1'b0;
      stat_wr  <= 1'b0;
      if (st_r == TSO_IDLE && start_req && hdr_len <= 8'(MAX_HDR)) begin
        desc_req  <= 1'b1;
        desc_addr <= desc_base;
      end else if (st_r == TSO_TXW && tx_done && frames_r[0]) begin
        desc_req  <= 1'b1;
        desc_addr <= desc_addr + TSO_DESC_PAIR;
      end
      if (st_r == TSO_STAT) begin
        stat_wr    <= 1'b1;
        stat_fails <= fails_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_mid_payload;
    @(posedge hclk) disable iff (!hresetn)
      frm_valid && !frm_data.last && seg_en |-> frm_data.payload_len == max_pay;
  endproperty
  a_mid_payload: assert property (p_mid_payload)
    else $error("mid payload not max");

  property p_first_flags;
    @(posedge hclk) disable iff (!hresetn)
      frm_valid && !frm_data.last |-> (frm_data.flags & finpsh) == 6'h00;
  endproperty
  a_first_flags: assert property (p_first_flags)
    else $error("fin or psh left set");

  property p_last_flags;
    @(posedge hclk) disable iff (!hresetn)
      frm_valid && frm_data.last |-> frm_data.flags == pflags;
  endproperty
  a_last_flags: assert property (p_last_flags)
    else $error("last flags differ");

  property p_id_step;
    @(posedge hclk) disable iff (!hresetn)
      st_r == TSO_TXW && tx_done && !is_last |=> id_r == $past(id_r) + 16'h0001;
  endproperty
  a_id_step: assert property (p_id_step)
    else $error("ip id not incremented");

  property p_seq_step;
    @(posedge hclk) disable iff (!hresetn)
      st_r == TSO_TXW && tx_done |=> seq_r == $past(seq_r) + {16'h0000, $past(pay_len)};
  endproperty
  a_seq_step: assert property (p_seq_step)
    else $error("sequence step wrong");

  property p_last_len;
    @(posedge hclk) disable iff (!hresetn)
      frm_valid && frm_data.last |->
        frm_data.ip_tot_len == len_r[15:0] - (max_pay - frm_data.payload_len);
  endproperty
  a_last_len: assert property (p_last_len)
    else $error("last ip length wrong");

  property p_one_status;
    @(posedge hclk) disable iff (!hresetn)
      stat_wr |-> !busy_r && $past(st_r) == TSO_STAT ##1 !stat_wr;
  endproperty
  a_one_status: assert property (p_one_status)
    else $error("status write misplaced");

  property p_sched_hold;
    @(posedge hclk) disable iff (!hresetn)
      st_r == TSO_SCHED && time_r < sched_r |=> !frm_valid;
  endproperty
  a_sched_hold: assert property (p_sched_hold)
    else $error("frame before schedule");

  property p_hdr_refuse;
    @(posedge hclk) disable iff (!hresetn)
      st_r == TSO_IDLE && start_req && hdr_len > 8'(MAX_HDR) |=> hdrerr_r && !busy_r;
  endproperty
  a_hdr_refuse: assert property (p_hdr_refuse)
    else $error("oversize header accepted");

  property p_urg_keep;
    @(posedge hclk) disable iff (!hresetn)
      frm_valid |-> frm_data.urg_ptr == ipid_r[31:16];
  endproperty
  a_urg_keep: assert property (p_urg_keep)
    else $error("urgent pointer changed");

  property p_mid_pseudo;
    @(posedge hclk) disable iff (!hresetn)
      frm_valid && !frm_data.last |-> frm_data.pseudo_sum == hdr_r[15:0];
  endproperty
  a_mid_pseudo: assert property (p_mid_pseudo)
    else $error("mid pseudo sum changed");

  property p_last_payload;
    @(posedge hclk) disable iff (!hresetn)
      frm_valid && frm_data.last && seg_en |-> frm_data.payload_len <= max_pay;
  endproperty
  a_last_payload: assert property (p_last_payload)
    else $error("last payload above max");

endmodule

// [verification/tso_tx_model.sv]
// tso_tx_model: checksum and transmit stage facing the engine.
// assumes one clock; bench sets stall cycles and failing frames.
`timescale 1ns/1ps
module tso_tx_model
  import tso_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       frm_valid,
  input  wire logic [2:0] stall,
  input  wire logic [7:0] fail_mask,
  output logic            frm_ready,
  output logic            tx_done,
  output logic            tx_fail
);
  logic [2:0] cnt_r;
  logic [2:0] idx_r;
  logic       busy_r;

  // take a frame after the stall, report it after a flight time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frm_ready <= 1'b0;
      tx_done   <= 1'b0;
      tx_fail   <= 1'b0;
      cnt_r     <= 3'h0;
      idx_r     <= 3'h0;
      busy_r    <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      tx_fail <= ~tx_fail; // junk unless tx_done
      if (busy_r) begin
        cnt_r <= cnt_r + 3'h1;
        if (cnt_r == 3'h3) begin
          busy_r  <= 1'b0;
          cnt_r   <= 3'h0;
          tx_done <= 1'b1;
          tx_fail <= fail_mask[idx_r];
          idx_r   <= idx_r + 3'h1;
        end
      end else if (frm_ready && frm_valid) begin
        frm_ready <= 1'b0;
        busy_r    <= 1'b1;
        cnt_r     <= 3'h0;
      end else if (frm_valid) begin
        cnt_r <= cnt_r + 3'h1;
        if (cnt_r >= stall) frm_ready <= 1'b1;
      end
    end
  end
endmodule

// [verification/tso_engine_test.sv]
// tso_engine_test: self-checking bench for the segmentation engine.
// assumes tso_tx_model as transmit stage; the bench is the bus master.
`timescale 1ns/1ps
module tso_engine_test;
  import tso_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [31:0] DBASE = 32'h0000_4000;
  localparam logic [15:0] IPID  = 16'h1234;
  localparam logic [15:0] URG   = 16'h0005;
  localparam logic [15:0] TLEN  = 16'h0154;
  localparam logic [15:0] SNAP  = 16'h015c;
  localparam logic [15:0] PSUM  = 16'h8a3c;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  tso_frame_s  frm_data;
  logic        frm_valid, frm_ready, tx_done, tx_fail, desc_req, stat_wr;
  logic [31:0] desc_addr;
  logic [31:0] first_desc;
  logic [7:0]  stat_fails;
  logic [2:0]  stall = 3'h0;
  logic [7:0]  fail_mask = 8'h00;
  tso_frame_s  got[$];
  int          bad_count = 0;
  int          checked = 0;
  int          cyc = 0;
  int          stat_n, done_n, done_at_stat, desc_n;

  // clock, 8 ns period
  always #4 hclk = ~hclk;

  tso_engine dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .frm_data(frm_data), .frm_valid(frm_valid), .frm_ready(frm_ready),
    .tx_done(tx_done), .tx_fail(tx_fail), .desc_req(desc_req),
    .desc_addr(desc_addr), .desc_base(DBASE), .stat_wr(stat_wr),
    .stat_fails(stat_fails));

  tso_tx_model tx_u (.hclk(hclk), .hresetn(hresetn), .frm_valid(frm_valid),
    .stall(stall), .fail_mask(fail_mask), .frm_ready(frm_ready),
    .tx_done(tx_done), .tx_fail(tx_fail));

  // ----------------------------------------------------------------
  // monitor and timeout
  // ----------------------------------------------------------------
  // collect accepted frames, count strobes, cut a hang short
  always @(posedge hclk) begin
    if (hresetn !== 1'b1) begin
      got.delete();
      stat_n = 0;
      done_n = 0;
      desc_n = 0;
    end else begin
      if (frm_valid === 1'b1 && frm_ready === 1'b1) got.push_back(frm_data);
      if (tx_done === 1'b1) done_n++;
      if (stat_wr === 1'b1) begin
        stat_n++;
        done_at_stat = done_n;
      end
      if (desc_req === 1'b1) begin
        if (desc_n == 0) first_desc = desc_addr;
        desc_n++;
      end
    end
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one single ahb-lite transfer, waiting on hready in both phases
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    check({31'h0000_0000, hresp}, 32'h0000_0000); // always okay
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0000_0000, q);
    check(q, e);
  endtask

  task automatic do_reset();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  // ones-complement subtraction of a length from a partial sum
  function automatic logic [15:0] oc_sub(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, ~b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

  // status at reset, read-only and unmapped places, oversized header
  task automatic hdr_err();
    do_reset();
    rd(TSO_OFF_STAT, TSO_RST_WORD);
    wr(TSO_OFF_STAT, 32'hffff_ffff);
    rd(TSO_OFF_STAT, TSO_RST_WORD);
    rd(8'h3c, 32'h0000_0000);
    wr(TSO_OFF_HDR, 32'h5100_0000);
    wr(TSO_OFF_CTRL, 32'h0000_0001);
    repeat (20) @(posedge hclk);
    check(got.size(), 0);
    rd(TSO_OFF_STAT, 32'h0000_0004);
  endtask

  // one full session checked frame by frame, then its status
  task automatic session(input logic [4:0] act, input logic [15:0] tot,
                         input logic [13:0] mx, input logic [31:0] seq,
                         input logic [5:0] flg, input int nf,
                         input logic [2:0] stl, input logic [7:0] fm);
    tso_frame_s  f;
    logic [15:0] pl;
    logic [15:0] cut;
    logic [31:0] t;
    int          fails;
    fails = 0;
    @(posedge hclk);
    stall     <= stl;
    fail_mask <= fm;
    do_reset();
    wr(TSO_OFF_ACT, {27'h000_0000, act});
    wr(TSO_OFF_PAYLD, {tot, 2'b00, mx});
    wr(TSO_OFF_SEQ, seq);
    wr(TSO_OFF_IPID, {URG, IPID});
    wr(TSO_OFF_LEN, {SNAP, TLEN});
    wr(TSO_OFF_HDR, {8'h50, 2'b00, flg, PSUM});
    if (act[TSO_ACT_SCHED]) begin
      ahb(1'b0, TSO_OFF_TIME, 32'h0000_0000, t);
      wr(TSO_OFF_SCHED, t + 32'h0000_012c);
    end
    wr(TSO_OFF_CTRL, 32'h0000_0001);
    wr(TSO_OFF_PAYLD, 32'h0000_0001); // dropped while busy
    if (act[TSO_ACT_SCHED]) begin
      repeat (200) @(posedge hclk);
      check(got.size(), 0);
    end
    for (int k = 0; k < 4000 && stat_n == 0; k++) @(posedge hclk);
    check(got.size(), nf);
    for (int i = 0; i < nf; i++) begin
      f = got[i];
      pl = (i == nf - 1) ? tot - 16'(i) * {2'b00, mx} : {2'b00, mx};
      cut = {2'b00, mx} - pl;
      fails += fm[i];
      check(f.payload_len, pl);
      check(f.seq, seq + 32'(i) * {18'h0_0000, mx});
      check(f.ip_id, IPID + 16'(i));
      check(f.urg_ptr, URG);
      check(f.last, i == nf - 1);
      check({f.snap_en, f.ip_csum_req, f.tcp_csum_req}, {act[3], act[1], act[2]});
      check(f.flags, (i == nf - 1) ? flg : flg & 6'h36);
      if (act[TSO_ACT_SEG]) begin
        check(f.ip_tot_len, TLEN - cut);
        check(f.snap_len, SNAP - cut);
        check(f.pseudo_sum, oc_sub(PSUM, cut));
      end
    end
    ahb(1'b0, TSO_OFF_STAT, 32'h0000_0000, t);
    check(t, {16'(nf), 8'(fails), 8'h02});
    check(stat_fails, 8'(fails));
    check(stat_n, 1);
    check(done_at_stat, nf);
    check(first_desc, DBASE);
    check(desc_n, 1 + nf / 2);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin // hardware-parsed sends only
    hdr_err();
    session(5'h0f, 16'h03e8, 14'h012c, 32'hffff_ff00, 6'h19, 4, 3'h3, 8'h02);
    session(5'h01, 16'h0258, 14'h012c, 32'h1000_0000, 6'h10, 2, 3'h0, 8'h00);
    session(5'h06, 16'h00c8, 14'h012c, 32'h0000_0100, 6'h19, 1, 3'h0, 8'h00);
    session(5'h11, 16'h0190, 14'h0094, 32'h0000_7000, 6'h08, 3, 3'h1, 8'h05);
    print_verdict();
  end
endmodule
